/* logic/interleaved_acquisition_path.sv */
// Purpose: Acquisition data path of one input slot, from converters to the system bus.
// Assumes: Path samples arrive asynchronously on pins; one 200 MHz clock.
// Notes: Registers sit on a plain address, strobe and read-data port.
`timescale 1ns/10ps
`include "acq_consts.svh"

module interleaved_acquisition_path
   import acq_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wr_data,
   input  wire logic        i_wr_en,
   input  wire logic        i_rd_en,
   output logic [31:0]      o_rd_data,
   input  wire sample_type  i_path0_sample,
   input  wire sample_type  i_path1_sample,
   input  wire sample_type  i_path2_sample,
   input  wire sample_type  i_path3_sample,
   output logic [3:0]       o_path_strobe,
   output logic             o_ref_offset,
   output logic             o_busy,
   output logic             o_bus_valid,
   input  wire logic        i_bus_ready,
   output sample_type       o_bus_data
);
   // All state of the path.
   typedef struct packed {
      logic [3:0][7:0]   meta;       // First synchroniser stage.
      logic [3:0][7:0]   sync;       // Second synchroniser stage.
      logic [3:0][7:0]   group;      // Latched sample group.
      logic [1:0]        div;        // Sample tick divider.
      logic [2:0]        left;       // Words of the group still to store.
      acq_state_type     state;      // Capture sequence.
      logic              et;         // Equivalent-time mode.
      logic [1:0]        slots;      // Slot combination code.
      logic              ext;        // Extended memory.
      logic              avg;        // Averaging in equivalent time.
      logic [18:0]       count;      // Samples stored this record.
      logic              ovf;        // Sticky buffer overflow.
      logic [7:0]        cal_addr;   // Table load pointer.
      logic [255:0][7:0] cal_tab;    // Calibration lookup table.
      logic [7:0]        cal_data;   // Corrected sample.
      logic              cal_valid;  // Corrected sample waiting.
      logic [31:0]       rd_data;    // Read answer.
      logic [3:0]        strobe;     // Path sample strobes.
      logic              ref_off;    // Reference offset enable.
      logic              busy;       // Capture in progress, registered for the output.
   } path_state_type;

   path_state_type q;        // Registered state.
   path_state_type d;        // Next state.
   logic           tick;     // One cycle per sample group.
   logic           push;     // A word is offered to the buffer.
   sample_type     push_data;  // The offered word.
   logic           buf_ready;  // Buffer has room.
   logic           buf_valid;  // Buffer holds a word.
   sample_type     buf_data;   // Oldest buffered word.
   logic           pop;        // Oldest word goes to the table.
   logic           out_ready;  // Output buffer has room.
   logic [18:0]    depth;      // Record depth in force.
   logic [9:0]     sum;        // Sum of four synchronous samples.

   // Returns the record depth for the mode, memory size and slot count.
   function automatic logic [18:0] record_depth(input logic et, input logic ext,
                                                input logic [1:0] slots);
      logic [18:0] base;
      base = ext ? `DEPTH_EXT : `DEPTH_BASE;
      record_depth = et ? base : (base << slots);
   endfunction

   // Returns the aggregate sample rate in MSa/s.
   function automatic logic [15:0] rate_msps(input logic et, input logic [1:0] slots);
      if (et) begin
         rate_msps = `PATH_RATE_MSPS;
      end else begin
         rate_msps = 16'((`PATH_RATE_MSPS << 2) << slots);
      end
   endfunction

   // The outputs all come from flip-flops.
   assign o_rd_data     = q.rd_data;
   assign o_path_strobe = q.strobe;
   assign o_ref_offset  = q.ref_off;
   assign o_busy        = q.busy;
   assign depth         = record_depth(q.et, q.ext, q.slots);
   assign tick          = (q.div == `TICK_CYCLES);
   assign sum           = 10'(q.sync[0]) + 10'(q.sync[1]) + 10'(q.sync[2]) + 10'(q.sync[3]);

   // Computes the whole next state of the path.
   always_comb begin
      d         = q;
      push      = 1'b0;
      push_data = 8'h00;
      d.rd_data = 32'h0000_0000;
      // Two flip-flops before any logic reads the pins.
      d.meta = {i_path3_sample, i_path2_sample, i_path1_sample, i_path0_sample};
      d.sync = q.meta;
      d.div  = tick ? 2'h0 : q.div + 2'h1;
      if (!q.et) begin
         d.strobe = 4'h1 << d.div;
      end else begin
         d.strobe = (d.div == 2'h0) ? 4'hF : 4'h0;
      end
      d.ref_off = q.et;

      // Register writes; a hardware flag set below wins over a clear here.
      if (i_wr_en) begin
         case (i_addr)
            `REG_CTRL: begin
               d.et    = i_wr_data[`CTRL_ET];
               d.slots = (i_wr_data[`CTRL_SLOTS] == 2'h3) ? 2'h2 : i_wr_data[`CTRL_SLOTS];
               d.ext   = i_wr_data[`CTRL_EXT];
               d.avg   = i_wr_data[`CTRL_AVG];
               // Arming restarts the record from zero unless a capture stores a word in the same cycle.
               if (i_wr_data[`CTRL_ARM]) begin
                  d.state = ST_CAPTURE;
                  d.count = 19'h00000;
                  d.left  = 3'h0;
               end
            end
            `REG_STATUS: begin
               // Writing one clears the overflow flag.
               if (i_wr_data[`STAT_OVF]) begin
                  d.ovf = 1'b0;
               end
            end
            `REG_CAL_ADDR: begin
               d.cal_addr = i_wr_data[7:0];
            end
            `REG_CAL_DATA: begin
               d.cal_tab[q.cal_addr] = i_wr_data[7:0];
               d.cal_addr            = q.cal_addr + 8'h01;
            end
            default: begin
               d.cal_addr = q.cal_addr;
            end
         endcase
      end

      // Capture sequence feeding the fast-in-slow-out buffer.
      case (q.state)
         ST_IDLE, ST_DONE: begin
            d.left = 3'h0;
         end
         ST_CAPTURE: begin
            if (q.et) begin
               if (tick) begin
                  push = 1'b1;
                  push_data = q.avg ? sum[9:2] : q.sync[0];
               end
            end else begin
               // The last word of a group falls on the next tick, so it is stored in the same cycle as the new group is latched.
               // words stored in time order
               if (q.left != 3'h0) begin
                  push      = 1'b1;
                  push_data = q.group[2'(3'h4 - q.left)];
                  d.left    = q.left - 3'h1;
               end
               if (tick) begin
                  d.group = q.sync;
                  d.left  = 3'h4;
               end
            end
            if (push) begin
               if (buf_ready) begin
                  d.count = q.count + 19'h00001;
                  if (d.count >= depth) begin
                     d.state = ST_DONE;
                  end
               end else begin
                  d.ovf = 1'b1;
               end
            end
         end
         default: begin
            d.state = ST_IDLE;
         end
      endcase

      // The busy output is taken from its own flip-flop, in step with the state.
      d.busy = (d.state == ST_CAPTURE);

      pop = buf_valid && (!q.cal_valid || out_ready);
      if (q.cal_valid && out_ready) begin
         d.cal_valid = 1'b0;
      end
      if (pop) begin
         d.cal_data  = q.cal_tab[buf_data];
         d.cal_valid = 1'b1;
      end

      // Read answers stand in the cycle after the strobe.
      if (i_rd_en) begin
         case (i_addr)
            `REG_CTRL: begin
               d.rd_data = {26'h0, q.avg, q.ext, q.slots, q.et, 1'b0};
            end
            `REG_STATUS: begin
               d.rd_data = {29'h0, q.ovf, q.state == ST_DONE, q.state == ST_CAPTURE};
            end
            `REG_COUNT: begin
               d.rd_data = {13'h0, q.count};
            end
            `REG_RATE: begin
               d.rd_data = {16'h0, rate_msps(q.et, q.slots)};
            end
            `REG_CAL_ADDR: begin
               d.rd_data = {24'h0, q.cal_addr};
            end
            `REG_CAL_DATA: begin
               d.rd_data = {24'h0, q.cal_tab[q.cal_addr]};
            end
            default: begin
               d.rd_data = 32'h0000_0000;
            end
         endcase
      end
   end

   // Registers the state; the table starts as the identity mapping.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         q <= '0;
         for (int i = 0; i < 256; i++) begin
            q.cal_tab[i] <= 8'(i);
         end
      end else begin
         q <= d;
      end
   end

   fast_in_slow_out_buffer u_hold (
      .i_clk      (i_clk),
      .i_resetn   (i_resetn),
      .i_wr_valid (push),
      .o_wr_ready (buf_ready),
      .i_wr_data  (push_data),
      .o_rd_valid (buf_valid),
      .i_rd_ready (pop),
      .o_rd_data  (buf_data)
   );

   two_entry_buffer u_out (
      .i_clk       (i_clk),
      .i_resetn    (i_resetn),
      .i_in_valid  (q.cal_valid),
      .o_in_ready  (out_ready),
      .i_in_data   (q.cal_data),
      .o_out_valid (o_bus_valid),
      .i_out_ready (i_bus_ready),
      .o_out_data  (o_bus_data)
   );
endmodule // interleaved_acquisition_path

/* logic/acq_consts.svh */
// Purpose: Constants of the acquisition path: offsets, fields, reset values and timing.
// Assumes: A 200 MHz system clock and 32-bit register data.
// Notes: Included by bare name from every design file but the package.
`ifndef ACQ_CONSTS_SVH
`define ACQ_CONSTS_SVH

// Clock period and one sampling path period, in picoseconds.
`define CLK_PERIOD_PS    5000
`define PATH_PERIOD_PS   2000
// Last count of the sample divider; groups of the four paths come four clock cycles apart.
`define TICK_CYCLES      2'h3
// Register byte offsets.
`define REG_CTRL         8'h00
`define REG_STATUS       8'h04
`define REG_COUNT        8'h08
`define REG_RATE         8'h0C
`define REG_CAL_ADDR     8'h10
`define REG_CAL_DATA     8'h14
// Control field positions.
`define CTRL_ARM         0
`define CTRL_ET          1
`define CTRL_SLOTS       3:2
`define CTRL_EXT         4
`define CTRL_AVG         5
// Status field positions.
`define STAT_BUSY        0
`define STAT_DONE        1
`define STAT_OVF         2
// Reset value of the control register.
`define CTRL_RESET       6'h00
// Record depths per slot, basic and extended memory.
`define DEPTH_BASE       19'h04000
`define DEPTH_EXT        19'h10000
// Rate of one sampling path in MSa/s.
`define PATH_RATE_MSPS   16'h01F4
// Depth and pointer width of the fast-in-slow-out buffer.
`define BUF_DEPTH        13'h1000
`define BUF_AW           12

`endif

/* logic/acq_pkg.sv */
// Purpose: Types shared by the acquisition path modules.
// Assumes: Nothing beyond the constants header.
// Notes: Capture states are Gray coded along idle, capture, done.
package acq_pkg;
   // Capture sequence of one record.
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_CAPTURE = 2'b01,
      ST_DONE    = 2'b11
   } acq_state_type;
   // One converted sample.
   typedef logic [7:0] sample_type;
endpackage

/* logic/fast_in_slow_out_buffer.sv */
// Purpose: 4K-deep sample buffer between the converters and the bus side.
// Assumes: Writer and reader share one clock.
// Notes: Refuses writes while full, so nothing is overwritten.
`timescale 1ns/10ps
`include "acq_consts.svh"
module fast_in_slow_out_buffer
   import acq_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_resetn,
   input  wire logic       i_wr_valid,
   output logic            o_wr_ready,
   input  wire sample_type i_wr_data,
   output logic            o_rd_valid,
   input  wire logic       i_rd_ready,
   output sample_type      o_rd_data
);
   // All buffer state.
   typedef struct packed {
      logic [4095:0][7:0]  mem;  // Sample storage.
      logic [`BUF_AW:0]    wp;   // Write pointer with wrap bit.
      logic [`BUF_AW:0]    rp;   // Read pointer with wrap bit.
   } buf_state_type;

   buf_state_type q;   // Registered state.
   buf_state_type d;   // Next state.
   logic          full;  // No free entry.

   // Full when pointers differ by the whole depth; empty when equal.
   assign full       = ((q.wp - q.rp) == `BUF_DEPTH);
   assign o_wr_ready = !full;
   assign o_rd_valid = (q.wp != q.rp);
   assign o_rd_data  = q.mem[q.rp[`BUF_AW-1:0]];

   // Next state: store on an accepted write, advance on an accepted read.
   always_comb begin
      d = q;
      if (i_wr_valid && !full) begin
         d.mem[q.wp[`BUF_AW-1:0]] = i_wr_data;
         d.wp = q.wp + 1'b1;
      end
      if (i_rd_ready && o_rd_valid) begin
         d.rp = q.rp + 1'b1;
      end
   end

   // Registers the state; reset clears the storage along with the pointers.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule // fast_in_slow_out_buffer

/* logic/two_entry_buffer.sv */
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: One clock; the drain side may stall at any time.
// Notes: Ready and valid both come from flip-flops.
`timescale 1ns/10ps
`include "acq_consts.svh"
module two_entry_buffer
   import acq_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_resetn,
   input  wire logic       i_in_valid,
   output logic            o_in_ready,
   input  wire sample_type i_in_data,
   output logic            o_out_valid,
   input  wire logic       i_out_ready,
   output sample_type      o_out_data
);
   // All buffer state.
   typedef struct packed {
      logic [7:0] d0;  // Head word.
      logic [7:0] d1;  // Second word.
      logic       v0;  // Head holds a word.
      logic       v1;  // Second holds a word.
   } two_state_type;

   two_state_type q;  // Registered state.
   two_state_type d;  // Next state.

   assign o_in_ready  = !q.v1;
   assign o_out_valid = q.v0;
   assign o_out_data  = q.d0;

   // Pop shifts the second word forward; a push fills the first free slot.
   always_comb begin
      d = q;
      if (q.v0 && i_out_ready) begin
         d.d0 = q.d1;
         d.v0 = q.v1;
         d.v1 = 1'b0;
      end
      if (i_in_valid && !q.v1) begin
         if (!d.v0) begin
            d.d0 = i_in_data;
            d.v0 = 1'b1;
         end else begin
            d.d1 = i_in_data;
            d.v1 = 1'b1;
         end
      end
   end

   // Registers the state.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule // two_entry_buffer

/* sim/acq_path_props.sv */
// Purpose: Port assertions of the acquisition path.
// Assumes: One clock and an asynchronous active-low reset.
// Notes: Bound to the top module after the checker.
`timescale 1ns/10ps
module acq_path_props
   import acq_pkg::*;
(
   input wire logic        i_clk,
   input wire logic        i_resetn,
   input wire logic [7:0]  i_addr,
   input wire logic [31:0] i_wr_data,
   input wire logic        i_wr_en,
   input wire logic        i_rd_en,
   input wire logic [31:0] o_rd_data,
   input wire sample_type  i_path0_sample,
   input wire sample_type  i_path1_sample,
   input wire sample_type  i_path2_sample,
   input wire sample_type  i_path3_sample,
   input wire logic [3:0]  o_path_strobe,
   input wire logic        o_ref_offset,
   input wire logic        o_busy,
   input wire logic        o_bus_valid,
   input wire logic        i_bus_ready,
   input wire sample_type  o_bus_data
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   logic [3:0] strobe_q;   // Strobes one cycle back.
   logic [1:0] et_q;       // Mode history, so mode changes are skipped.
   logic [1:0] wr_q;       // Recent control writes.
   // Keep short histories of strobes, mode and control writes.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         strobe_q <= 4'h0;
         et_q     <= 2'h0;
         wr_q     <= 2'h0;
      end else begin
         strobe_q <= o_path_strobe;
         et_q     <= {et_q[0], o_ref_offset};
         wr_q     <= {wr_q[0], i_wr_en && i_addr == 8'h00};
      end
   end
   a_rd_idle_zero: assert property (!$past(i_rd_en) |-> o_rd_data == 32'h0)
      else $error("read data seen outside a read slot");
   a_unmapped_zero: assert property (i_rd_en && i_addr > 8'h14 |=> o_rd_data == 32'h0)
      else $error("unmapped read gave nonzero data");
   a_ref_follow: assert property (i_wr_en && i_addr == 8'h00 |-> ##2 o_ref_offset == $past(i_wr_data[1], 2))
      else $error("reference offset does not follow the mode");
   a_et_rate: assert property (i_rd_en && i_addr == 8'h0C && o_ref_offset |=> o_rd_data == 32'h1F4)
      else $error("equivalent time rate is wrong");
   a_rt_one_path: assert property (et_q == 2'h0 && !o_ref_offset && wr_q == 2'h0 |-> $onehot0(o_path_strobe))
      else $error("more than one path strobed in real time");
   a_rt_rotate: assert property (et_q == 2'h0 && !o_ref_offset && wr_q == 2'h0 && strobe_q != 4'h0
      |-> o_path_strobe == {strobe_q[2:0], strobe_q[3]})
      else $error("path strobes not staggered in order");
   a_et_cadence: assert property (o_ref_offset && et_q == 2'h3 && o_path_strobe == 4'hF
      |=> (o_path_strobe == 4'h0) [*3] ##1 o_path_strobe == 4'hF)
      else $error("synchronous strobe cadence broken");
   a_bus_hold: assert property (o_bus_valid && !i_bus_ready |=> o_bus_valid && $stable(o_bus_data))
      else $error("bus word changed or vanished while stalled");
   a_arm_busy: assert property (i_wr_en && i_addr == 8'h00 && i_wr_data[0] |-> ##[1:2] o_busy)
      else $error("arming did not start a record");
   c_stall: cover property (o_bus_valid && !i_bus_ready);
   c_sync: cover property (o_path_strobe == 4'hF);
   c_busy: cover property ($fell(o_busy));
endmodule // acq_path_props

bind interleaved_acquisition_path acq_path_props chk (.*);

/* sim/bus_sink_model.sv */
// Purpose: System bus side that accepts corrected words.
// Assumes: Mode 0 always ready, 1 every other cycle, 2 stalled.
// Notes: Accepted words are kept in a queue for the bench.
`timescale 1ns/10ps
module bus_sink_model
   import acq_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_resetn,
   input  wire logic [1:0] i_mode,
   input  wire logic       i_valid,
   input  wire sample_type i_data,
   output logic            o_ready
);
   sample_type got[$];   // Words in order of acceptance.
   // Take a word on each edge where valid and ready meet, then pace ready.
   always @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_ready <= 1'b0;
      end else begin
         if (i_valid === 1'b1 && o_ready) begin
            got.push_back(i_data);
         end
         o_ready <= (i_mode == 2'h0) || (i_mode == 2'h1 && !o_ready);
      end
   end
endmodule // bus_sink_model

/* sim/tb_interleaved_acquisition_path.sv */
// Purpose: Self-checking bench of the acquisition path.
// Assumes: 200 MHz clock and the sink model on the bus side.
// Notes: The cal table is loaded with inverted values.
`timescale 1ns/10ps
`include "acq_consts.svh"
module tb_interleaved_acquisition_path
   import acq_pkg::*;
   ;
   logic        i_clk, i_resetn, i_wr_en, i_rd_en, i_bus_ready;
   logic [7:0]  i_addr;
   logic [31:0] i_wr_data, o_rd_data, rdv;
   logic [3:0]  o_path_strobe;
   logic        o_ref_offset, o_busy, o_bus_valid;
   logic [1:0]  mode;
   sample_type  p0, p1, p2, p3, o_bus_data;
   int          errors, checked;
   interleaved_acquisition_path uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
      .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
      .i_path0_sample(p0), .i_path1_sample(p1), .i_path2_sample(p2), .i_path3_sample(p3),
      .o_path_strobe(o_path_strobe), .o_ref_offset(o_ref_offset), .o_busy(o_busy),
      .o_bus_valid(o_bus_valid), .i_bus_ready(i_bus_ready), .o_bus_data(o_bus_data));
   bus_sink_model snk (.i_clk(i_clk), .i_resetn(i_resetn), .i_mode(mode), .i_valid(o_bus_valid),
      .i_data(o_bus_data), .o_ready(i_bus_ready));
   // Compare one value and count it.
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
      end
   endtask
   // Print the counts and the verdict, then stop.
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // One-cycle register write.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_addr    <= a;
      i_wr_data <= d;
      i_wr_en   <= 1'b1;
      @(posedge i_clk);
      i_wr_en <= 1'b0;
   endtask
   // One-cycle register read; data is taken in the following cycle.
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_clk);
      i_addr  <= a;
      i_rd_en <= 1'b1;
      @(posedge i_clk);
      i_rd_en <= 1'b0;
      #1;
      d = o_rd_data;
   endtask
   // Poll the done flag under a bound.
   task automatic wait_done();
      for (int k = 0; k < 50000; k++) begin
         rd(`REG_STATUS, rdv);
         if (rdv[`STAT_DONE] === 1'b1) return;
      end
      errors++;
      print_verdict();
   endtask
   // Wait until the sink holds n words, under a bound.
   task automatic drain(input int n);
      for (int k = 0; k < 6000; k++) begin
         if (snk.got.size() >= n) return;
         @(posedge i_clk);
      end
      errors++;
      print_verdict();
   endtask
   // Reset values, cal table access and rates of every slot code.
   task automatic t_regs();
      rd(`REG_CTRL, rdv);
      chk("ctrl", 32'h0, rdv);
      rd(`REG_RATE, rdv);
      chk("rate", 32'h7D0, rdv);
      rd(8'h20, rdv);
      chk("unmapped", 32'h0, rdv);
      wr(`REG_CAL_ADDR, 32'h33);
      rd(`REG_CAL_DATA, rdv);
      chk("cal default", 32'h33, rdv);
      wr(`REG_CAL_ADDR, 32'h0);
      for (int i = 0; i < 256; i++) wr(`REG_CAL_DATA, 32'hFF ^ i);
      wr(`REG_CAL_ADDR, 32'h5);
      rd(`REG_CAL_DATA, rdv);
      chk("cal entry", 32'hFA, rdv);
      for (int s = 0; s < 4; s++) begin
         wr(`REG_CTRL, s << 2);
         rd(`REG_RATE, rdv);
         chk("slot rate", 32'h7D0 << (s > 2 ? 2 : s), rdv);
      end
      $display("test registers done");
   endtask
   // Real time record with the bus stalled long enough to overflow.
   task automatic t_rt();
      sample_type pv[4] = '{8'h11, 8'h22, 8'h33, 8'h44};
      int bad = 0;
      @(posedge i_clk);
      p0 <= pv[0];
      p1 <= pv[1];
      p2 <= pv[2];
      p3 <= pv[3];
      mode <= 2'h2;
      wr(`REG_CTRL, 32'h0);
      wr(`REG_CTRL, 32'h1);
      repeat (8000) @(posedge i_clk);
      mode <= 2'h0;
      wait_done();
      rd(`REG_STATUS, rdv);
      chk("overflow", 32'h1, rdv[`STAT_OVF]);
      wr(`REG_STATUS, 32'h4);
      rd(`REG_STATUS, rdv);
      chk("overflow clear", 32'h0, rdv[`STAT_OVF]);
      rd(`REG_COUNT, rdv);
      chk("count", 32'h4000, rdv);
      drain(16384);
      chk("words", 16384, snk.got.size());
      for (int i = 0; i < 4096; i++) if (snk.got[i] !== (8'hFF ^ pv[i % 4])) bad++;
      chk("order", 0, bad);
      $display("test real time done");
   endtask
   // Averaged equivalent time record with the bus pacing at half rate.
   task automatic t_et();
      int bad = 0;
      snk.got.delete();
      @(posedge i_clk);
      p0 <= 8'h10;
      p1 <= 8'h20;
      p2 <= 8'h30;
      p3 <= 8'h40;
      mode <= 2'h1;
      wr(`REG_CTRL, 32'h22);
      rd(`REG_RATE, rdv);
      chk("et rate", 32'h1F4, rdv);
      chk("ref offset", 32'h1, o_ref_offset);
      wr(`REG_CTRL, 32'h23);
      wait_done();
      rd(`REG_COUNT, rdv);
      chk("et count", 32'h4000, rdv);
      drain(16384);
      foreach (snk.got[i]) if (snk.got[i] !== 8'hD7) bad++;
      chk("average", 0, bad);
      $display("test equivalent time done");
   endtask
   // Free-running 200 MHz clock.
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   // Reset, then the scenarios in turn.
   initial begin
      i_resetn  = 1'b0;
      i_wr_en   = 1'b0;
      i_rd_en   = 1'b0;
      i_addr    = 8'h00;
      i_wr_data = 32'h0;
      mode      = 2'h0;
      p0        = 8'h00;
      p1        = 8'h00;
      p2        = 8'h00;
      p3        = 8'h00;
      errors    = 0;
      checked   = 0;
      repeat (16) @(posedge i_clk);
      i_resetn <= 1'b1;
      t_regs();
      t_rt();
      t_et();
      print_verdict();
   end
endmodule // tb_interleaved_acquisition_path
